// ===== lnb_ctrl.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "lnb_regs.svh"
// Contract
// - Modes zero: internal tone gated by modulation pin
// - Tone enable gives continuous tone
// - Modulation select passes external tone through
// - Oscillator runs at twenty times tone
// - Detect output pulled low on tone
// - Power control low shuts everything down
// - Pin enable: trims alone set voltage
// - Otherwise range pin picks trim range
// - Dynamic mode uses selected limit threshold
// - Overcurrent past 51 ms: 900 ms off
// - Off period ends: flag clears, soft-start
// - Persistent overcurrent repeats trip cycle
// - Static mode clamps, flags until soft-start ends
// - Back current past 2 ms: 50 ms off
// - Back current cycles until condition clears
// - Overtemp shuts off, flag until cooled
// - Fourth overtemp latches part off
// - Power control toggle clears latch, count
// - Undervoltage lockout disables all operation
// - Fault output low on any fault except back current
// - All bits zero at power-on
module lnb_ctrl #(
  parameter lnb_pkg::lnb_tmr_t OVL_TRIP_TK = 19'(`LNB_US2TK(`LNB_OVL_TRIP_US)),
  parameter lnb_pkg::lnb_tmr_t OVL_OFF_TK = 19'(`LNB_US2TK(`LNB_OVL_OFF_US)),
  parameter lnb_pkg::lnb_tmr_t SOFT_TK = 19'(`LNB_US2TK(`LNB_SOFT_US)),
  parameter lnb_pkg::lnb_tmr_t BC_TRIP_TK = 19'(`LNB_US2TK(`LNB_BC_TRIP_US)),
  parameter lnb_pkg::lnb_tmr_t BC_OFF_TK = 19'(`LNB_US2TK(`LNB_BC_OFF_US))
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire lnb_pkg::lnb_addr_t reg_addr,
  input wire lnb_pkg::lnb_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output lnb_pkg::lnb_data_t reg_rdata,
  // Pins
  input wire logic ext_modulation_in,
  input wire logic tone_detect_in,
  input wire logic transmit_threshold_sel,
  input wire logic range_select_pin,
  // Analog sense
  input wire logic overcurrent_in,
  input wire logic back_current_in,
  input wire logic overtemp_in,
  input wire logic uvlo_in,
  input wire logic serial_reset_in,
  // Open-drain outputs
  output logic tone_detect_out_o,
  output logic tone_detect_out_oe_n,
  output logic fault_n_o,
  output logic fault_n_oe_n,
  // Power and tone control
  output logic tone_out,
  output logic detect_thr_tx,
  output logic boost_enable,
  output logic output_enable,
  output logic soft_start,
  output logic static_clamp,
  output logic [1:0] limit_sel,
  output logic [1:0] level_sel
);
  import lnb_pkg::*;

  // ********************
  // Input synchronisers
  // ********************
  logic [8:0] pin_s;
  logic mod_s, det_in_s, thr_s, rsel_s, oc_s, bc_s, ot_s, uvlo_s, srst_s;
  lnb_sync #(.W(9)) i_lnb_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({ext_modulation_in, tone_detect_in, transmit_threshold_sel, range_select_pin,
        overcurrent_in, back_current_in, overtemp_in, uvlo_in, serial_reset_in}),
    .q(pin_s)
  );
  assign {mod_s, det_in_s, thr_s, rsel_s, oc_s, bc_s, ot_s, uvlo_s, srst_s} = pin_s;

  logic osc_tick, tone_sq;
  lnb_osc i_lnb_osc (
    .clk_sys(clk_sys),
    .rst(rst),
    .osc_tick(osc_tick),
    .tone_sq(tone_sq)
  );

  // ********************
  // Control registers
  // ********************
  logic tone_en_reg, mod_sel_reg, static_reg, pin_en_reg, lim_hi_reg, lim_lo_reg;
  logic en_reg, high_trim_reg, low_trim_reg;
  lnb_data_t rdata_reg;
  wire wr_tone = reg_wr && (reg_addr == `LNB_A_TONE);
  wire wr_cmd = reg_wr && (reg_addr == `LNB_A_CMD);
  wire wr_ctrl = reg_wr && (reg_addr == `LNB_A_CTRL);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tone_en_reg <= 1'b0;
      mod_sel_reg <= 1'b0;
      static_reg <= 1'b0;
      pin_en_reg <= 1'b0;
      lim_hi_reg <= 1'b0;
      lim_lo_reg <= 1'b0;
      en_reg <= 1'b0;
      high_trim_reg <= 1'b0;
      low_trim_reg <= 1'b0;
    end else begin
      if (wr_tone) begin
        tone_en_reg <= reg_wdata[`LNB_B_TONE_EN];
        mod_sel_reg <= reg_wdata[`LNB_B_MOD_SEL];
      end
      if (wr_cmd) begin
        static_reg <= reg_wdata[`LNB_B_STATIC];
        pin_en_reg <= reg_wdata[`LNB_B_PIN_EN];
        lim_hi_reg <= reg_wdata[`LNB_B_LIM_HI];
        lim_lo_reg <= reg_wdata[`LNB_B_LIM_LO];
      end
      if (wr_ctrl) begin
        en_reg <= reg_wdata[`LNB_B_EN];
        high_trim_reg <= reg_wdata[`LNB_B_HIGH_TRIM];
        low_trim_reg <= reg_wdata[`LNB_B_LOW_TRIM];
      end
    end
  end

  // ********************
  // Protection sequencer
  // ********************
  lnb_state_t state_reg, state_next;
  lnb_tmr_t tmr_reg, tmr_next;
  logic [14:0] oc_cnt_reg;
  logic [9:0] bc_cnt_reg;
  logic [2:0] ot_cnt_reg;
  logic ovl_static_reg, first_soft_reg;

  function automatic logic lnb_on(input lnb_state_t s);
    lnb_on = (s == LNB_SOFT) || (s == LNB_RUN);
  endfunction : lnb_on

  wire is_on = lnb_on(state_reg);
  wire tmr_done = osc_tick && (tmr_reg == '0);
  wire oc_trip = !static_reg && (oc_cnt_reg == OVL_TRIP_TK[14:0]);
  wire bc_trip = (bc_cnt_reg == BC_TRIP_TK[9:0]);
  wire ot_event = is_on && ot_s;
  wire soft_end = (state_reg == LNB_SOFT) && (state_next == LNB_RUN);

  always_comb begin
    state_next = state_reg;
    tmr_next = (osc_tick && tmr_reg != '0) ? tmr_reg - 19'h00001 : tmr_reg;
    if (!en_reg) begin
      state_next = LNB_OFF;
    end else if (uvlo_s) begin
      state_next = (state_reg == LNB_LATCH) ? LNB_LATCH : LNB_OFF;
    end else begin
      unique case (state_reg)
        LNB_OFF: begin
          state_next = LNB_SOFT;
          tmr_next = SOFT_TK;
        end
        LNB_SOFT, LNB_RUN: begin
          if (ot_s) begin
            state_next = (ot_cnt_reg == `LNB_OT_LATCH_CNT - 3'h1) ? LNB_LATCH : LNB_OT;
          end else if (oc_trip) begin
            state_next = LNB_OVL;
            tmr_next = OVL_OFF_TK;
          end else if (bc_trip) begin
            state_next = LNB_BC;
            tmr_next = BC_OFF_TK;
          end else if (state_reg == LNB_SOFT && tmr_done) begin
            state_next = LNB_RUN;
          end
        end
        LNB_OVL: begin
          if (tmr_done) begin
            state_next = LNB_SOFT;
            tmr_next = SOFT_TK;
          end
        end
        LNB_BC: begin
          if (tmr_done) state_next = LNB_RUN;
        end
        LNB_OT: begin
          if (!ot_s) begin
            state_next = LNB_SOFT;
            tmr_next = SOFT_TK;
          end
        end
        LNB_LATCH: state_next = LNB_LATCH;
        default: state_next = LNB_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= LNB_OFF;
      tmr_reg <= '0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oc_cnt_reg <= 15'h0000;
      bc_cnt_reg <= 10'h000;
    end else begin
      if (!(is_on && oc_s && !static_reg) || oc_trip) oc_cnt_reg <= 15'h0000;
      else if (osc_tick) oc_cnt_reg <= oc_cnt_reg + 15'h0001;
      if (!(is_on && bc_s) || bc_trip) bc_cnt_reg <= 10'h000;
      else if (osc_tick) bc_cnt_reg <= bc_cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ot_cnt_reg <= 3'h0;
    end else if (!en_reg) begin
      ot_cnt_reg <= 3'h0;
    end else if (ot_event && !uvlo_s && ot_cnt_reg != `LNB_OT_LATCH_CNT) begin
      ot_cnt_reg <= ot_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovl_static_reg <= 1'b0;
      first_soft_reg <= 1'b0;
    end else begin
      if (static_reg && is_on && oc_s) ovl_static_reg <= 1'b1;
      else if (soft_end && first_soft_reg) ovl_static_reg <= 1'b0;
      if (state_reg == LNB_OFF) first_soft_reg <= 1'b1;
      else if (soft_end) first_soft_reg <= 1'b0;
    end
  end

  // ********************
  // Status and outputs
  // ********************
  // flag over the off period
  wire ovl_flag = (state_reg == LNB_OVL) || ovl_static_reg;
  wire back_flag = (state_reg == LNB_BC);
  wire ot_flag = (state_reg == LNB_OT) || (state_reg == LNB_LATCH);
  wire fault = ot_flag || ovl_flag || uvlo_s || srst_s;
  wire [1:0] vsel_w = pin_en_reg ? {high_trim_reg, low_trim_reg} :
                      rsel_s ? {1'b1, high_trim_reg} : {1'b0, low_trim_reg};
  wire tone_w = tone_en_reg ? tone_sq : mod_sel_reg ? mod_s : (mod_s && tone_sq);
  wire [7:0] st_w = {3'h0, ot_flag, 1'b0, uvlo_s, ovl_flag, back_flag};
  wire [7:0] rd_w = (reg_addr == `LNB_A_STATUS) ? st_w :
                    (reg_addr == `LNB_A_TONE) ? {3'h0, tone_en_reg, mod_sel_reg, 3'h0} :
                    (reg_addr == `LNB_A_CMD) ?
                      {3'h0, static_reg, pin_en_reg, 1'b0, lim_hi_reg, lim_lo_reg} :
                      {3'h0, en_reg, 2'h0, high_trim_reg, low_trim_reg};
  logic tone_reg, det_reg, fault_reg, thr_reg;
  logic [1:0] vsel_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tone_reg <= 1'b0;
      det_reg <= 1'b0;
      fault_reg <= 1'b0;
      thr_reg <= 1'b0;
      vsel_reg <= 2'h0;
      rdata_reg <= `LNB_RST_VAL;
    end else begin
      tone_reg <= tone_w && is_on;
      det_reg <= det_in_s;
      fault_reg <= fault;
      thr_reg <= thr_s;
      vsel_reg <= vsel_w;
      rdata_reg <= reg_rd ? rd_w : `LNB_RST_VAL;
    end
  end

  assign reg_rdata = rdata_reg;
  assign tone_out = tone_reg;
  assign detect_thr_tx = thr_reg;
  assign tone_detect_out_o = 1'b0;
  assign tone_detect_out_oe_n = ~det_reg;
  assign fault_n_o = 1'b0;
  assign fault_n_oe_n = ~fault_reg;
  assign boost_enable = is_on;
  assign output_enable = is_on;
  assign soft_start = (state_reg == LNB_SOFT);
  assign static_clamp = static_reg;
  assign limit_sel = {lim_hi_reg, lim_lo_reg};
  assign level_sel = vsel_reg;

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_ovl_expire;
    state_reg == LNB_OVL && tmr_done && en_reg && !uvlo_s;
  endsequence
  sequence s_soft_run;
    state_reg == LNB_SOFT && !ovl_flag;
  endsequence

  property p_tone_cont;
    tone_en_reg && is_on && $stable(tone_en_reg) |=> tone_out == $past(tone_sq);
  endproperty
  a_tone_cont: assert property (p_tone_cont) else $error("tone not continuous");
  property p_ext_pass;
    !tone_en_reg && mod_sel_reg && is_on |=> tone_out == $past(mod_s);
  endproperty
  a_ext_pass: assert property (p_ext_pass) else $error("ext tone not passed");
  property p_gate;
    !tone_en_reg && !mod_sel_reg && !mod_s |=> !tone_out;
  endproperty
  a_gate: assert property (p_gate) else $error("tone not gated");
  property p_shutdown;
    !en_reg |=> !output_enable && !boost_enable;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no shutdown");
  property p_vsel;
    pin_en_reg ##1 $stable(pin_en_reg) |-> level_sel == $past({high_trim_reg, low_trim_reg});
  endproperty
  a_vsel: assert property (p_vsel) else $error("voltage select wrong");
  property p_ovl_end;
    s_ovl_expire |=> s_soft_run;
  endproperty
  a_ovl_end: assert property (p_ovl_end) else $error("no soft-start after off");
  property p_ovl_flag;
    is_on && oc_trip && !ot_s && en_reg && !uvlo_s |=> ovl_flag && !output_enable && tmr_reg == OVL_OFF_TK;
  endproperty
  a_ovl_flag: assert property (p_ovl_flag) else $error("overload flag low");
  property p_bc;
    is_on && bc_trip && !oc_trip && !ot_s && en_reg && !uvlo_s |=> back_flag && !output_enable;
  endproperty
  a_bc: assert property (p_bc) else $error("back-current off wrong");
  property p_latch;
    ot_event && en_reg && !uvlo_s && ot_cnt_reg == 3'h3 |=> state_reg == LNB_LATCH ##1 ot_flag;
  endproperty
  a_latch: assert property (p_latch) else $error("no latch on fourth");
  property p_fault;
    uvlo_s |=> !fault_n_oe_n;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not driven");
  property p_uvlo;
    uvlo_s |=> !boost_enable;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("lockout ignored");
endmodule : lnb_ctrl

// ===== lnb_regs.svh
`ifndef LNB_REGS_SVH
`define LNB_REGS_SVH

// ********************
// Register addresses
// ********************
`define LNB_A_STATUS 2'h0
`define LNB_A_TONE 2'h1
`define LNB_A_CMD 2'h2
`define LNB_A_CTRL 2'h3
`define LNB_RST_VAL 8'h00

// ********************
// Field positions
// ********************
`define LNB_B_BACK_FLAG 0
`define LNB_B_OVL_FLAG 1
`define LNB_B_UVLO 2
`define LNB_B_OT_FLAG 4
`define LNB_B_MOD_SEL 3
`define LNB_B_TONE_EN 4
`define LNB_B_LIM_LO 0
`define LNB_B_LIM_HI 1
`define LNB_B_PIN_EN 3
`define LNB_B_STATIC 4
`define LNB_B_LOW_TRIM 0
`define LNB_B_HIGH_TRIM 1
`define LNB_B_EN 4

// ********************
// Timing
// ********************
`define LNB_CLK_HZ 50000000
`define LNB_TONE_HZ 22000
`define LNB_OSC_MULT 20
`define LNB_OSC_HZ (`LNB_TONE_HZ * `LNB_OSC_MULT)
`define LNB_OSC_DIV (`LNB_CLK_HZ / `LNB_OSC_HZ)
`define LNB_TONE_HALF (`LNB_OSC_MULT / 2)
`define LNB_OVL_TRIP_US 51000
`define LNB_OVL_OFF_US 900000
`define LNB_SOFT_US 20000
`define LNB_BC_TRIP_US 2000
`define LNB_BC_OFF_US 50000
`define LNB_US2TK(us) (((us) * (`LNB_OSC_HZ / 10000)) / 100)
`define LNB_OT_LATCH_CNT 3'h4

`endif

// ===== lnb_pkg.sv
package lnb_pkg;
  typedef enum logic [2:0] {
    LNB_OFF, LNB_SOFT, LNB_RUN, LNB_OVL, LNB_BC, LNB_OT, LNB_LATCH
  } lnb_state_t;
  typedef logic [1:0] lnb_addr_t;
  typedef logic [7:0] lnb_data_t;
  typedef logic [18:0] lnb_tmr_t;
endpackage : lnb_pkg

// ===== lnb_sync.sv
`timescale 1ns/1ns
module lnb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule : lnb_sync

// ===== lnb_osc.sv
`timescale 1ns/1ns
`include "lnb_regs.svh"
module lnb_osc (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Oscillator outputs
  output logic osc_tick,
  output logic tone_sq
);
  logic [6:0] div_reg;
  logic [3:0] ph_reg;
  logic sq_reg;
  logic tick_reg;
  wire div_end = (div_reg == 7'(`LNB_OSC_DIV - 1));
  wire ph_end = (ph_reg == 4'(`LNB_TONE_HALF - 1));

  // Tone is the oscillator divided by twenty
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg <= 7'h00;
      ph_reg <= 4'h0;
      sq_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_end ? 7'h00 : div_reg + 7'h01;
      tick_reg <= div_end;
      if (div_end) begin
        ph_reg <= ph_end ? 4'h0 : ph_reg + 4'h1;
        if (ph_end) sq_reg <= ~sq_reg;
      end
    end
  end

  assign osc_tick = tick_reg;
  assign tone_sq = sq_reg;
endmodule : lnb_osc

// ===== lnb_host_model.sv
`timescale 1ns/1ns
// **********************
// Host register master
// **********************
module lnb_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output lnb_pkg::lnb_addr_t reg_addr,
  output lnb_pkg::lnb_data_t reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire lnb_pkg::lnb_data_t reg_rdata
);
  import lnb_pkg::*;
  initial begin
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input lnb_addr_t a, input lnb_data_t v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // Data only stands in the cycle after the strobe
  task automatic rd(input lnb_addr_t a, output lnb_data_t v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask : rd
  task automatic power_cycle();
    wr(2'h3, 8'h00);
    wr(2'h3, 8'h10);
  endtask : power_cycle
endmodule : lnb_host_model

// ===== tb_lnb_ctrl.sv
`timescale 1ns/1ns
`include "lnb_regs.svh"
module tb_lnb_ctrl;
  import lnb_pkg::*;
  // ****************
  // Signals
  // ****************
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  lnb_addr_t reg_addr;
  lnb_data_t reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd;
  logic ext_modulation_in = 1'b0, tone_detect_in = 1'b0, transmit_threshold_sel = 1'b0;
  logic range_select_pin = 1'b0, overcurrent_in = 1'b0, back_current_in = 1'b0;
  logic overtemp_in = 1'b0, uvlo_in = 1'b0, serial_reset_in = 1'b0;
  logic tone_detect_out_o, tone_detect_out_oe_n, fault_n_o, fault_n_oe_n, tone_out;
  logic detect_thr_tx, boost_enable, output_enable, soft_start, static_clamp;
  logic [1:0] limit_sel, level_sel;
  int n_errors = 0, check_count = 0, k, t;
  // Rows: command, control, range pin, voltage code
  lnb_data_t rows [8][4] = '{'{8'h00, 8'h10, 8'h00, 8'h00}, '{8'h01, 8'h11, 8'h00, 8'h01},
    '{8'h02, 8'h11, 8'h01, 8'h02}, '{8'h03, 8'h12, 8'h01, 8'h03},
    '{8'h08, 8'h10, 8'h01, 8'h00}, '{8'h09, 8'h11, 8'h01, 8'h01},
    '{8'h1a, 8'h12, 8'h00, 8'h02}, '{8'h0b, 8'h13, 8'h00, 8'h03}};
  wire [3:0] watch = {fault_n_oe_n, tone_out, soft_start, output_enable};
  always #10 clk_sys = ~clk_sys;
  // Short counts keep the protection cycles within a few thousand clocks
  lnb_ctrl #(.OVL_TRIP_TK(19'h8), .OVL_OFF_TK(19'h14), .SOFT_TK(19'h5),
    .BC_TRIP_TK(19'h3), .BC_OFF_TK(19'ha)) i_lnb_ctrl (.clk_sys, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_modulation_in, .tone_detect_in,
    .transmit_threshold_sel, .range_select_pin, .overcurrent_in, .back_current_in,
    .overtemp_in, .uvlo_in, .serial_reset_in, .tone_detect_out_o, .tone_detect_out_oe_n,
    .fault_n_o, .fault_n_oe_n, .tone_out, .detect_thr_tx, .boost_enable, .output_enable,
    .soft_start, .static_clamp, .limit_sel, .level_sel);
  lnb_host_model i_lnb_host_model (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  // ****************
  // Tasks
  // ****************
  task automatic report_and_stop();
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic st(input lnb_data_t exp);
    i_lnb_host_model.rd(`LNB_A_STATUS, d);
    chk(d, exp);
  endtask : st
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // Bounded wait; running out ends the run
  task automatic wait_for(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && watch[s] !== v; i++) @(posedge clk_sys);
    chk(8'(watch[s]), 8'(v));
    if (watch[s] !== v) report_and_stop();
  endtask : wait_for
  task automatic toggles(input int n, output int c);
    logic p;
    c = 0;
    p = tone_out;
    repeat (n) begin
      @(posedge clk_sys);
      if (tone_out !== p) c++;
      p = tone_out;
    end
  endtask : toggles
  // ****************
  // Sequence
  // ****************
  initial begin
    cyc(4);
    rst <= 1'b0;
    for (k = 0; k < 4; k++) begin
      i_lnb_host_model.rd(2'(k), d);
      chk(d, 8'h00);
    end
    chk(8'({fault_n_oe_n, tone_detect_out_oe_n, output_enable}), 8'h06);
    for (k = 0; k < 8; k++) begin
      i_lnb_host_model.wr(`LNB_A_CMD, rows[k][0]);
      i_lnb_host_model.wr(`LNB_A_CTRL, rows[k][1]);
      range_select_pin <= rows[k][2][0];
      cyc(6);
      chk(8'(level_sel), rows[k][3]);
      chk(8'({static_clamp, limit_sel}), 8'({rows[k][0][4], rows[k][0][1:0]}));
    end
    i_lnb_host_model.wr(`LNB_A_CMD, 8'h00);
    wait_for(0, 1'b1, 2000);
    toggles(2400, t);
    chk(8'(t), 8'h00);
    // tone enable stays low during bursts
    ext_modulation_in <= 1'b1;
    toggles(4520, t);
    chk(8'(t >= 3 && t <= 5), 8'h01);
    ext_modulation_in <= 1'b0;
    i_lnb_host_model.wr(`LNB_A_TONE, 8'h10);
    toggles(4520, t);
    chk(8'(t >= 3 && t <= 5), 8'h01);
    i_lnb_host_model.wr(`LNB_A_TONE, 8'h08);
    ext_modulation_in <= 1'b1;
    cyc(6);
    chk(8'(tone_out), 8'h01);
    ext_modulation_in <= 1'b0;
    cyc(6);
    chk(8'(tone_out), 8'h00);
    i_lnb_host_model.wr(`LNB_A_TONE, 8'h00);
    tone_detect_in <= 1'b1;
    transmit_threshold_sel <= 1'b1;
    cyc(6);
    chk(8'({tone_detect_out_o, tone_detect_out_oe_n, detect_thr_tx}), 8'h01);
    tone_detect_in <= 1'b0;
    overcurrent_in <= 1'b1;
    wait_for(0, 1'b0, 1500);
    st(8'h02);
    chk(8'({tone_detect_out_oe_n, detect_thr_tx}), 8'h03);
    chk(8'(fault_n_oe_n), 8'h00);
    wait_for(1, 1'b1, 2600);
    st(8'h00);
    wait_for(0, 1'b0, 1500);
    st(8'h02);
    overcurrent_in <= 1'b0;
    wait_for(0, 1'b1, 3500);
    // static mode first for heavy loads
    i_lnb_host_model.wr(`LNB_A_CMD, 8'h10);
    overcurrent_in <= 1'b1;
    cyc(1500);
    chk(8'(output_enable), 8'h01);
    st(8'h02);
    overcurrent_in <= 1'b0;
    i_lnb_host_model.power_cycle();
    wait_for(1, 1'b1, 20);
    wait_for(1, 1'b0, 1000);
    st(8'h00);
    i_lnb_host_model.wr(`LNB_A_CMD, 8'h00);
    back_current_in <= 1'b1;
    wait_for(0, 1'b0, 800);
    st(8'h01);
    wait_for(0, 1'b1, 1500);
    wait_for(0, 1'b0, 800);
    back_current_in <= 1'b0;
    wait_for(0, 1'b1, 1500);
    st(8'h00);
    for (k = 0; k < 4; k++) begin
      overtemp_in <= 1'b1;
      wait_for(0, 1'b0, 20);
      st(8'h10);
      chk(8'(fault_n_oe_n), 8'h00);
      overtemp_in <= 1'b0;
      cyc(1500);
      chk(8'(output_enable), 8'(k < 3));
    end
    st(8'h10);
    i_lnb_host_model.power_cycle();
    wait_for(0, 1'b1, 1500);
    st(8'h00);
    uvlo_in <= 1'b1;
    wait_for(0, 1'b0, 20);
    st(8'h04);
    wait_for(3, 1'b0, 20);
    uvlo_in <= 1'b0;
    wait_for(0, 1'b1, 1500);
    serial_reset_in <= 1'b1;
    wait_for(3, 1'b0, 20);
    serial_reset_in <= 1'b0;
    wait_for(3, 1'b1, 20);
    i_lnb_host_model.wr(`LNB_A_CTRL, 8'h00);
    wait_for(0, 1'b0, 20);
    chk(8'({boost_enable, tone_out, fault_n_o}), 8'h00);
    // Mid-run reset must clear bits written just before it
    i_lnb_host_model.wr(`LNB_A_TONE, 8'h18);
    rst <= 1'b1;
    cyc(4);
    rst <= 1'b0;
    for (k = 0; k < 4; k++) begin
      i_lnb_host_model.rd(2'(k), d);
      chk(d, 8'h00);
    end
    report_and_stop();
  end
endmodule : tb_lnb_ctrl
